// *** common/reg_port_if.sv ***
// Carrier between the serial-clock link engine and the system-clock register store.
// Every request is a toggle; its words stand still until the next toggle.
`timescale 1ns/10ps
interface reg_port_if;
   logic       wrTog;
   logic [7:0] wrAddr;
   logic [7:0] wrData;
   logic       rdTog;
   logic [7:0] rdAddr;
   logic [7:0] rdData;
   logic       startTog;
   logic       stopTog;

   modport link
   (
      output wrTog,
      output wrAddr,
      output wrData,
      output rdTog,
      output rdAddr,
      output startTog,
      output stopTog,
      input  rdData
   );

   modport store
   (
      input  wrTog,
      input  wrAddr,
      input  wrData,
      input  rdTog,
      input  rdAddr,
      input  startTog,
      input  stopTog,
      output rdData
   );
endinterface

// *** common/twi_slave_pkg.sv ***
// Constants and types shared by the two-wire register access slave.
// Assumes a fast system clock next to a host-driven serial clock.
package twi_slave_pkg;

   // ***************************************************************
   // Bus and register space
   // ***************************************************************
   localparam logic [6:0] SLAVE_ADDR  = 7'h32;
   localparam logic [7:0] PTR_RESET   = 8'h00;
   localparam logic [7:0] PTR_STEP    = 8'h01;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [2:0] BIT_FIRST   = 3'h0;
   localparam int         REG_COUNT   = 256;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int STD_SCL_KHZ    = 100;
   localparam int FAST_SCL_KHZ   = 400;
   localparam int MCLK_MHZ       = 200;
   localparam int MCLK_NS        = 1000 / MCLK_MHZ;
   // Half a fast-mode period is the time a read request has to be served.
   localparam int FAST_HALF_NS   = 1000000 / (2 * FAST_SCL_KHZ);
   localparam int SERVE_CYCLES   = FAST_HALF_NS / MCLK_NS;
   // Two synchroniser stages, one edge stage and one array read.
   localparam int STORE_LATENCY  = 4;

   // ***************************************************************
   // Link state machine
   // ***************************************************************
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } linkState_t;

endpackage

// *** core/reg_store.sv ***
// Register array and request handling on the system clock.
// Assumes requests arrive as toggles from the serial-clock domain.
`timescale 1ns/10ps
module reg_store
   import twi_slave_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   reg_port_if.store       port,
   output logic            wrStrobe,
   output logic [7:0]      wrAddrOut,
   output logic [7:0]      wrDataOut,
   output logic            busActive
);
   import twi_slave_pkg::*;

   // ***************************************************************
   // Toggle synchronisers
   // ***************************************************************
   logic [3:0] togIn;
   logic [3:0] syncA;
   logic [3:0] syncB;
   logic [3:0] syncC;
   logic [3:0] togEdge;
   logic [7:0] mem [REG_COUNT];
   logic [7:0] rdData;
   logic [7:0] next_rdData;
   logic       next_wrStrobe;
   logic [7:0] next_wrAddrOut;
   logic [7:0] next_wrDataOut;
   logic       next_busActive;

   assign togIn = {port.stopTog, port.startTog, port.rdTog, port.wrTog};

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gSync
         always_ff @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               syncA[g] <= 1'b0;
               syncB[g] <= 1'b0;
               syncC[g] <= 1'b0;
            end
            else
            begin
               syncA[g] <= togIn[g];
               syncB[g] <= syncA[g];
               syncC[g] <= syncB[g];
            end
         end
      end
   endgenerate

   assign togEdge = syncB ^ syncC;

   // ***************************************************************
   // Array access
   // ***************************************************************
   // The address and data words are stable long before their toggle is seen here.
   always_ff @(posedge mclk)
   begin
      if (togEdge[0])
      begin
         mem[port.wrAddr] <= port.wrData;
      end
   end

   always_comb
   begin
      next_rdData    = rdData;
      next_wrStrobe  = togEdge[0];
      next_wrAddrOut = wrAddrOut;
      next_wrDataOut = wrDataOut;
      next_busActive = busActive;
      if (togEdge[1])
      begin
         next_rdData = mem[port.rdAddr];
      end
      if (togEdge[0])
      begin
         next_wrAddrOut = port.wrAddr;
         next_wrDataOut = port.wrData;
      end
      if (togEdge[3])
      begin
         next_busActive = 1'b0;
      end
      if (togEdge[2])
      begin
         next_busActive = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdData    <= 8'h00;
         wrStrobe  <= 1'b0;
         wrAddrOut <= 8'h00;
         wrDataOut <= 8'h00;
         busActive <= 1'b0;
      end
      else
      begin
         rdData    <= next_rdData;
         wrStrobe  <= next_wrStrobe;
         wrAddrOut <= next_wrAddrOut;
         wrDataOut <= next_wrDataOut;
         busActive <= next_busActive;
      end
   end

   assign port.rdData = rdData;
endmodule

// *** core/twi_reg_slave.sv ***
// Two-wire bus slave giving a host byte access to a 256-entry register array.
// Assumes open-drain bus pins resolved outside and a host that owns the serial clock.
`timescale 1ns/10ps
module twi_reg_slave
   import twi_slave_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       sclClk,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   output logic            regWrStrobe,
   output logic [7:0]      regWrAddr,
   output logic [7:0]      regWrData,
   output logic            busActive
);
   import twi_slave_pkg::*;

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   // A read request must be served within half a fast-mode clock period.
   generate
      if (STORE_LATENCY >= SERVE_CYCLES)
      begin : gTooSlow
         $error("System clock too slow for a 400 kHz serial clock.");
      end
      if (FAST_SCL_KHZ < STD_SCL_KHZ)
      begin : gBadRates
         $error("Fast mode rate must not be below standard mode rate.");
      end
   endgenerate

   // ***************************************************************
   // Declarations
   // ***************************************************************
   reg_port_if port ();

   logic       startTog;
   logic       next_startTog;
   logic       stopTog;
   logic       next_stopTog;

   linkState_t state;
   linkState_t next_state;
   logic [2:0] bitCnt;
   logic [2:0] next_bitCnt;
   logic [7:0] shiftIn;
   logic [7:0] next_shiftIn;
   logic [7:0] rxByte;
   logic       byteDone;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic [7:0] ptrInc;
   logic       isRead;
   logic       next_isRead;
   logic       startSeen;
   logic       next_startSeen;
   logic       wrTog;
   logic       next_wrTog;
   logic [7:0] wrAddr;
   logic [7:0] next_wrAddr;
   logic [7:0] wrData;
   logic [7:0] next_wrData;
   logic       rdTog;
   logic       next_rdTog;
   logic [7:0] rdAddr;
   logic [7:0] next_rdAddr;

   logic [7:0] txShift;
   logic [7:0] next_txShift;
   logic       next_sdaOe;
   logic       next_sdaOut;

   // ***************************************************************
   // Start and stop detection
   // ***************************************************************
   // Data edges while the clock is high mark frame boundaries. The host only
   // moves data while the clock is high to frame, so these flops see the clock
   // level settled, and the slave never moves data while the clock is high.
   always_comb
   begin
      next_startTog = startTog;
      next_stopTog  = stopTog;
      if (sclClk)
      begin
         next_startTog = ~startTog;
         next_stopTog  = ~stopTog;
      end
   end

   always_ff @(negedge sdaIn or negedge rst_n)
   begin
      if (!rst_n)
      begin
         startTog <= 1'b0;
      end
      else
      begin
         startTog <= next_startTog;
      end
   end

   always_ff @(posedge sdaIn or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stopTog <= 1'b0;
      end
      else
      begin
         stopTog <= next_stopTog;
      end
   end

   // ***************************************************************
   // Receive side, rising serial clock edge
   // ***************************************************************
   // A start toggles well before the next rising edge, so that edge can
   // compare it with the last one seen without a synchroniser.
   assign rxByte   = {shiftIn[6:0], sdaIn};
   assign byteDone = (bitCnt == BIT_LAST);
   assign ptrInc   = ptr + PTR_STEP;

   always_comb
   begin
      next_state     = state;
      next_bitCnt    = bitCnt;
      next_shiftIn   = shiftIn;
      next_ptr       = ptr;
      next_isRead    = isRead;
      next_startSeen = startSeen;
      next_wrTog     = wrTog;
      next_wrAddr    = wrAddr;
      next_wrData    = wrData;
      next_rdTog     = rdTog;
      next_rdAddr    = rdAddr;
      if (startTog != startSeen)
      begin
         // A start or repeated start always restarts the frame.
         next_startSeen = startTog;
         next_state     = ST_ADDR;
         next_shiftIn   = rxByte;
         next_bitCnt    = 3'h1;
      end
      else
      begin
         case (state)
            ST_ADDR:
            begin
               next_shiftIn = rxByte;
               next_bitCnt  = bitCnt + 3'h1;
               if (byteDone)
               begin
                  if (rxByte[7:1] == SLAVE_ADDR)
                  begin
                     next_isRead = rxByte[0];
                     next_state  = ST_ADDR_ACK;
                  end
                  else
                  begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               next_bitCnt = BIT_FIRST;
               if (isRead)
               begin
                  // The pointer as left by the last write, read or reset selects the first byte.
                  next_rdAddr = ptr;
                  next_rdTog  = ~rdTog;
                  next_state  = ST_RDATA;
               end
               else
               begin
                  next_state = ST_PTR;
               end
            end
            ST_PTR:
            begin
               next_shiftIn = rxByte;
               next_bitCnt  = bitCnt + 3'h1;
               if (byteDone)
               begin
                  next_ptr   = rxByte;
                  next_state = ST_PTR_ACK;
               end
            end
            ST_PTR_ACK:
            begin
               next_bitCnt = BIT_FIRST;
               next_state  = ST_WDATA;
            end
            ST_WDATA:
            begin
               next_shiftIn = rxByte;
               next_bitCnt  = bitCnt + 3'h1;
               if (byteDone)
               begin
                  next_wrAddr = ptr;
                  next_wrData = rxByte;
                  next_wrTog  = ~wrTog;
                  next_ptr    = ptrInc;
                  next_state  = ST_WDATA_ACK;
               end
            end
            ST_WDATA_ACK:
            begin
               next_bitCnt = BIT_FIRST;
               next_state  = ST_WDATA;
            end
            ST_RDATA:
            begin
               next_bitCnt = bitCnt + 3'h1;
               if (byteDone)
               begin
                  next_state = ST_RDATA_ACK;
               end
            end
            ST_RDATA_ACK:
            begin
               next_bitCnt = BIT_FIRST;
               next_ptr    = ptrInc;
               if (!sdaIn)
               begin
                  // Fetch the following byte at once; it is needed at the next fall.
                  next_rdAddr = ptrInc;
                  next_rdTog  = ~rdTog;
                  next_state  = ST_RDATA;
               end
               else
               begin
                  next_state = ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               next_bitCnt = BIT_FIRST;
            end
            default:
            begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sclClk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= ST_IDLE;
         bitCnt    <= BIT_FIRST;
         shiftIn   <= 8'h00;
         ptr       <= PTR_RESET;
         isRead    <= 1'b0;
         startSeen <= 1'b0;
         wrTog     <= 1'b0;
         wrAddr    <= 8'h00;
         wrData    <= 8'h00;
         rdTog     <= 1'b0;
         rdAddr    <= 8'h00;
      end
      else
      begin
         state     <= next_state;
         bitCnt    <= next_bitCnt;
         shiftIn   <= next_shiftIn;
         ptr       <= next_ptr;
         isRead    <= next_isRead;
         startSeen <= next_startSeen;
         wrTog     <= next_wrTog;
         wrAddr    <= next_wrAddr;
         wrData    <= next_wrData;
         rdTog     <= next_rdTog;
         rdAddr    <= next_rdAddr;
      end
   end

   // ***************************************************************
   // Drive side, falling serial clock edge
   // ***************************************************************
   // The pin is open drain: it is only ever pulled low, never driven high.
   // Read data is taken from the store half a clock period after the request;
   // the elaboration check above guarantees it has settled by then.
   always_comb
   begin
      next_txShift = txShift;
      next_sdaOe   = 1'b0;
      next_sdaOut  = 1'b0;
      case (state)
         ST_ADDR_ACK,
         ST_PTR_ACK,
         ST_WDATA_ACK:
         begin
            next_sdaOe = 1'b1;
         end
         ST_RDATA:
         begin
            if (bitCnt == BIT_FIRST)
            begin
               next_txShift = {port.rdData[6:0], 1'b0};
               next_sdaOe   = ~port.rdData[7];
            end
            else
            begin
               next_txShift = {txShift[6:0], 1'b0};
               next_sdaOe   = ~txShift[7];
            end
         end
         default:
         begin
            next_sdaOe = 1'b0;
         end
      endcase
   end

   always_ff @(negedge sclClk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txShift <= 8'h00;
         sdaOe   <= 1'b0;
         sdaOut  <= 1'b0;
      end
      else
      begin
         txShift <= next_txShift;
         sdaOe   <= next_sdaOe;
         sdaOut  <= next_sdaOut;
      end
   end

   // ***************************************************************
   // Register store on the system clock
   // ***************************************************************
   assign port.wrTog    = wrTog;
   assign port.wrAddr   = wrAddr;
   assign port.wrData   = wrData;
   assign port.rdTog    = rdTog;
   assign port.rdAddr   = rdAddr;
   assign port.startTog = startTog;
   assign port.stopTog  = stopTog;

   reg_store uStore
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .port      (port),
      .wrStrobe  (regWrStrobe),
      .wrAddrOut (regWrAddr),
      .wrDataOut (regWrData),
      .busActive (busActive)
   );
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the two-wire register slave, driven by a host model.
// Assumes the checker binds itself to the slave.
`timescale 1ns/10ps
module tb_top;
   import twi_slave_pkg::*;
   typedef struct packed
   {
      logic [7:0]  ptr;
      logic [31:0] data;
   } row_t;

   logic        mclk;
   logic        rst_n;
   logic        sclClk;
   logic        hostPull;
   logic        sdaOut;
   logic        sdaOe;
   logic        regWrStrobe;
   logic [7:0]  regWrAddr;
   logic [7:0]  regWrData;
   logic        busActive;
   logic        ack;
   logic [31:0] rd;
   logic [15:0] wrSeen[$];
   int          n_errors;
   int          comparisons;
   int          cycles;
   // Four-byte bursts; the middle row runs over the top register into the bottom.
   row_t        rows[3] = '{'{8'h88, 32'h5ac301fe}, '{8'hfe, 32'h11223344},
                            '{8'h40, 32'h00ff7e81}};
   // The data line has a pull-up, so it is low whenever either side pulls it.
   wire         sdaLine = !(hostPull || sdaOe);

   twi_reg_slave DUT
   (
      .mclk, .rst_n, .sclClk, .sdaIn(sdaLine), .sdaOut, .sdaOe, .regWrStrobe, .regWrAddr,
      .regWrData, .busActive
   );
   twi_host_model host
   (
      .sclClk, .pullLow(hostPull), .sdaIn(sdaLine)
   );

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = !mclk;
   end

   // Outputs are taken at the falling edge, half a cycle after they settle.
   always @(negedge mclk)
   begin
      cycles++;
      if (regWrStrobe === 1'b1)
         wrSeen.push_back({regWrAddr, regWrData});
      if (cycles == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic checkWord(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic checkBit(input logic g, input logic e);
      checkWord({31'h0, g}, {31'h0, e});
   endtask

   task automatic doReset();
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      // Reset falls just after time zero, so every asynchronous reset sees a real edge.
      rst_n = 1'b1;
      #1;
      rst_n = 1'b0;
      doReset();
      checkWord({sdaOe, regWrStrobe, regWrAddr, regWrData, busActive}, 32'h0);
      foreach (rows[k])
      begin
         wrSeen = {};
         host.slowNs = (k == 2) ? 100 : 0;
         host.writeFrame(SLAVE_ADDR, rows[k].ptr, rows[k].data, 4, ack);
         checkBit(ack, 1'b0);
         checkWord(wrSeen.size(), 32'd4);
         for (int i = 0; i < 4; i++)
            checkWord(wrSeen[i], {8'(rows[k].ptr + i), rows[k].data[31 - 8 * i -: 8]});
         host.readFrame(1'b1, rows[k].ptr, 4, rd);
         checkWord(rd, rows[k].data);
      end
      host.slowNs = 0;
      host.readFrame(1'b1, 8'hff, 2, rd);
      checkWord(rd, 32'h2233);
      // A pointer-only write, then a read that relies on the pointer alone.
      host.writeFrame(SLAVE_ADDR, 8'h8a, 32'h0, 0, ack);
      host.readFrame(1'b0, 8'h00, 2, rd);
      checkWord(rd, 32'h01fe);
      wrSeen = {};
      host.writeFrame(7'h33, 8'h88, 32'hdeadbeef, 1, ack);
      checkBit(ack, 1'b1);
      checkWord(wrSeen.size(), 32'd0);
      host.readFrame(1'b1, 8'h88, 1, rd);
      checkWord(rd, 32'h5a);
      // Power cycle: the pointer restarts at zero while the array keeps its bytes.
      doReset();
      host.readFrame(1'b0, 8'h00, 1, rd);
      checkWord(rd, 32'h33);
      end_of_test();
   end
endmodule

// *** testbench/twi_host_model.sv ***
// Behavioural host that masters the two-wire bus towards the slave.
// Assumes a pull-up on the data line; pullLow high means the host pulls it low.
`timescale 1ns/10ps
module twi_host_model
   import twi_slave_pkg::*;
(
   output logic      sclClk,
   output logic      pullLow,
   input  wire logic sdaIn
);
   // Extra low time before each bit, so that a slow host can be played.
   int slowNs = 0;

   initial
   begin
      sclClk  = 1'b1;
      pullLow = 1'b0;
   end

   // ***************************************************************
   // Bus tasks
   // ***************************************************************
   // One bit per 48 ns; the clock stands high between frames.
   task automatic bitIo(input logic b, output logic r);
      pullLow = !b;
      #(12 + slowNs);
      sclClk = 1'b1;
      #12;
      r = sdaIn;
      #12;
      sclClk = 1'b0;
      #12;
   endtask

   task automatic startCond();
      pullLow = 1'b0;
      #12;
      sclClk = 1'b1;
      #12;
      pullLow = 1'b1;
      #12;
      sclClk = 1'b0;
      #12;
   endtask

   task automatic stopCond();
      pullLow = 1'b1;
      #12;
      sclClk = 1'b1;
      #12;
      pullLow = 1'b0;
      #24;
   endtask

   task automatic byteIo(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                         output logic ninth);
      for (int i = 7; i >= 0; i--)
         bitIo(tx[i], rx[i]);
      bitIo(last, ninth);
   endtask

   // Sends the pointer byte, then n bytes of d, most significant first.
   task automatic writeFrame(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [31:0] d, input int n, output logic addrAck);
      logic [7:0] rx;
      logic       a;
      startCond();
      byteIo({dev, 1'b0}, 1'b1, rx, addrAck);
      byteIo(ptr, 1'b1, rx, a);
      for (int i = 0; i < n; i++)
         byteIo(d[31 - 8 * i -: 8], 1'b1, rx, a);
      stopCond();
   endtask

   // Reads n bytes into q; the last one is answered by not-acknowledge.
   task automatic readFrame(input logic setPtr, input logic [7:0] ptr, input int n,
                            output logic [31:0] q);
      logic [7:0] rx;
      logic       a;
      q = 32'h0;
      startCond();
      if (setPtr)
      begin
         byteIo({SLAVE_ADDR, 1'b0}, 1'b1, rx, a);
         byteIo(ptr, 1'b1, rx, a);
         startCond();
      end
      byteIo({SLAVE_ADDR, 1'b1}, 1'b1, rx, a);
      for (int i = 0; i < n; i++)
      begin
         byteIo(8'hff, i == n - 1, rx, a);
         q = {q[23:0], rx};
      end
      stopCond();
   endtask
endmodule

// *** testbench/twi_reg_slave_properties.sv ***
// Concurrent checks on the ports of the two-wire register slave.
// Assumes a single system clock domain that samples the serial lines.
`timescale 1ns/10ps
module twi_reg_slave_properties
   import twi_slave_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       sclClk,
   input wire logic       sdaIn,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   input wire logic       regWrStrobe,
   input wire logic [7:0] regWrAddr,
   input wire logic [7:0] regWrData,
   input wire logic       busActive
);
   // Address of the previous write in the same frame, forgotten between frames.
   logic       prevValid;
   logic [7:0] prevAddr;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prevValid <= 1'b0;
      else
         prevValid <= regWrStrobe || (prevValid && busActive);
   end

   always_ff @(posedge mclk)
   begin
      if (regWrStrobe)
         prevAddr <= regWrAddr;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // ***************************************************************
   // Properties
   // ***************************************************************
   sequence startSeen;
      sclClk && $fell(sdaIn);
   endsequence

   sequence stopSeen;
      sclClk && $rose(sdaIn);
   endsequence

   a_drive_low: assert property (sdaOut == 1'b0)
      else $error("data output left its low level");
   a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclClk)
      else $error("data enable moved while the serial clock was high");
   a_idle_released: assert property (!busActive |-> !sdaOe)
      else $error("data line pulled outside a frame");
   a_strobe_pulse: assert property (regWrStrobe |=> !regWrStrobe)
      else $error("write strobe longer than one cycle");
   a_write_held: assert property (regWrStrobe |=> $stable(regWrAddr) && $stable(regWrData))
      else $error("write address or data moved after the strobe");
   a_ptr_step: assert property (regWrStrobe && prevValid |-> regWrAddr == prevAddr + PTR_STEP)
      else $error("burst write address did not step by one");
   a_start_active: assert property (startSeen |-> ##[1:6] busActive)
      else $error("start not followed by an active bus");
   a_stop_idle: assert property (stopSeen |-> ##[1:6] !busActive)
      else $error("stop not followed by an idle bus");
endmodule

bind twi_reg_slave twi_reg_slave_properties checker_inst
(
   .mclk, .rst_n, .sclClk, .sdaIn, .sdaOut, .sdaOe, .regWrStrobe, .regWrAddr, .regWrData,
   .busActive
);
